// ### pkg/timer_params.svh
// Register offsets, widths and reset values of the timer channel
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define TMR_ADDR_W        10
`define TMR_DATA_W        32
`define TMR_CNT_W         16

`define TMR_OFF_RUN       10'h180
`define TMR_OFF_MODE      10'h184
`define TMR_OFF_CMP0      10'h188
`define TMR_OFF_CMP1      10'h18c
`define TMR_OFF_CAP0      10'h190
`define TMR_OFF_CAP1      10'h194
`define TMR_OFF_FFCR      10'h198
`define TMR_OFF_COUNT     10'h19c

`define TMR_RUN_RESET     8'h00
`define TMR_MODE_RESET    9'h020
`define TMR_FFCR_RESET    4'h0
`define TMR_FF_RESET      1'b0

`define TMR_CNT_ZERO      16'h0000
`define TMR_CNT_ONE       16'h0001
`define TMR_CNT_MAX       16'hffff

`define TMR_GEAR_MAX      3'h4
`define TMR_FF_TOGGLE     2'b00
`define TMR_FF_SET        2'b01
`define TMR_FF_CLEAR      2'b10
`define TMR_FF_READBACK   2'b11

`endif

// ### pkg/timer_pkg.sv
// Types shared by the timer channel
package timer_pkg;

  typedef enum logic [1:0] {
    src_ext,
    src_t1,
    src_t4,
    src_t16
  } count_src_e;

  typedef enum logic [1:0] {
    cap_off,
    cap_clk_pin,
    cap_trig_pin,
    cap_out_flop
  } cap_mode_e;

  typedef struct packed {
    logic       double_buffer_enable;
    logic       reserved_zero;
    logic       idle_run_enable;
    logic       prescaler_run;
    logic       counter_run;
  } run_s;

  typedef struct packed {
    logic [2:0] clock_gear_select;
    logic       soft_capture_bit;
    cap_mode_e  capture_mode_select;
    logic       match_clear_enable;
    count_src_e count_clock_select;
  } mode_s;

  typedef struct packed {
    logic       one_on_capture_one;
    logic       one_on_capture_zero;
    logic       zero_on_match_one;
    logic       zero_on_match_zero;
  } ffcr_s;

  typedef struct packed {
    logic       overflow;
    logic       match_one;
    logic       match_zero;
    logic       ext_edge;
  } irq_s;

endpackage : timer_pkg

// ### rtl/timer_event_counter.sv
// One 16-bit timer/event counter channel with compare, capture and output flops
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "timer_params.svh"

module timer_event_counter (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_nrst,
  input  wire logic [`TMR_ADDR_W-1:0]  i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [`TMR_DATA_W-1:0]  i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [`TMR_DATA_W-1:0]  o_avs_readdata,
  output logic                         o_avs_waitrequest,
  input  wire logic                    i_ext_clock_input,
  input  wire logic                    i_capture_input,
  input  wire logic                    i_idle,
  output logic                         o_timer_out_zero,
  output logic                         o_timer_out_one,
  output timer_pkg::irq_s              o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  timer_pkg::run_s               run;
  timer_pkg::mode_s              mode;
  timer_pkg::ffcr_s              ffcr;
  logic [`TMR_CNT_W-1:0]         compare_zero;
  logic [`TMR_CNT_W-1:0]         compare_buffer;
  logic [`TMR_CNT_W-1:0]         compare_one;
  logic [`TMR_CNT_W-1:0]         capture [2];
  logic [`TMR_CNT_W-1:0]         up_counter;
  logic [3:0]                    gear_cnt;
  logic [1:0]                    quarter_cnt;
  logic [4:0]                    prescaler;
  logic [2:0]                    clk_pin_sync;
  logic [2:0]                    cap_pin_sync;
  logic                          count_q;
  logic [1:0]                    out_flop;
  logic                          prev_flop_one;
  logic [`TMR_DATA_W-1:0]        next_readdata;
  logic                          accept_wr;
  logic                          take_req;
  logic                          hold;
  logic                          gear_tick;
  logic                          phi_t0;
  logic                          tap_tick;
  logic                          count_tick;
  logic                          clk_rise;
  logic                          cap_rise;
  logic                          cap_fall;
  logic                          match_zero;
  logic                          match_one;
  logic                          clear_hit;
  logic                          overflow;
  logic                          soft_capture;
  logic [1:0]                    cap_ev;
  logic [1:0]                    flop_toggle;
  logic [1:0]                    flop_code [2];
  logic [1:0]                    flop_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Mask of low gear-counter bits that must be ones for one geared cycle
  function automatic logic [3:0] gear_mask(input logic [2:0] gear);
    logic [2:0] g;
    g = (gear > `TMR_GEAR_MAX) ? `TMR_GEAR_MAX : gear;
    gear_mask = 4'((5'h01 << g) - 5'h01);
  endfunction : gear_mask

  // Register hit of a word-aligned access
  function automatic logic hit(input logic [`TMR_ADDR_W-1:0] addr,
                               input logic [`TMR_ADDR_W-1:0] offs);
    hit = (addr[`TMR_ADDR_W-1:2] == offs[`TMR_ADDR_W-1:2]);
  endfunction : hit

  // Next value of an output flop from its control code and toggle event
  function automatic logic flop_next(input logic cur,
                                     input logic wr,
                                     input logic [1:0] code,
                                     input logic tog);
    logic v;
    v = cur;
    if (wr)
    begin
      unique case (code)
        `TMR_FF_TOGGLE : v = ~cur;
        `TMR_FF_SET    : v = 1'b1;
        `TMR_FF_CLEAR  : v = 1'b0;
        default        : v = cur;
      endcase
    end
    flop_next = tog ? ~v : v;
  endfunction : flop_next

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state, read data loads on the edge ending it, the write one edge later

  assign take_req  = (i_avs_read | i_avs_write) & o_avs_waitrequest;
  assign accept_wr = i_avs_write & ~o_avs_waitrequest;

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      o_avs_waitrequest <= 1'b1;
    else
      o_avs_waitrequest <= ~take_req;
  end

  always_comb
  begin
    next_readdata = '0;
    if (hit(i_avs_address, `TMR_OFF_RUN))
      next_readdata[7:0] = {run.double_buffer_enable, run.reserved_zero, 2'b00,
                            run.idle_run_enable, run.prescaler_run, 1'b0,
                            run.counter_run};
    else if (hit(i_avs_address, `TMR_OFF_MODE))
      next_readdata[8:0] = mode;
    else if (hit(i_avs_address, `TMR_OFF_CAP0))
      next_readdata[`TMR_CNT_W-1:0] = capture[0];
    else if (hit(i_avs_address, `TMR_OFF_CAP1))
      next_readdata[`TMR_CNT_W-1:0] = capture[1];
    else if (hit(i_avs_address, `TMR_OFF_FFCR))
      next_readdata[7:0] = {ffcr, `TMR_FF_READBACK, `TMR_FF_READBACK};
    else if (hit(i_avs_address, `TMR_OFF_COUNT))
      next_readdata[`TMR_CNT_W-1:0] = up_counter;
    // Compare registers read as zero
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      o_avs_readdata <= '0;
    else if (take_req && i_avs_read)
      o_avs_readdata <= next_readdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      run <= 5'(`TMR_RUN_RESET);
    else if (accept_wr && hit(i_avs_address, `TMR_OFF_RUN) && i_avs_byteenable[0])
      run <= {i_avs_writedata[7:6], i_avs_writedata[3:2], i_avs_writedata[0]};
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      mode <= `TMR_MODE_RESET;
    else if (accept_wr && hit(i_avs_address, `TMR_OFF_MODE))
    begin
      if (i_avs_byteenable[0])
        mode[7:0] <= i_avs_writedata[7:0];
      if (i_avs_byteenable[1])
        mode[8] <= i_avs_writedata[8];
    end
  end

  // Zero written always captures; one captures only over a stored zero
  assign soft_capture = accept_wr && hit(i_avs_address, `TMR_OFF_MODE)
                        && i_avs_byteenable[0]
                        && (!i_avs_writedata[5] || !mode.soft_capture_bit);

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      ffcr <= `TMR_FFCR_RESET;
    else if (accept_wr && hit(i_avs_address, `TMR_OFF_FFCR) && i_avs_byteenable[0])
      ffcr <= i_avs_writedata[7:4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare registers and buffer, byte-writable halves

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      compare_buffer <= `TMR_CNT_ZERO;
      compare_zero   <= `TMR_CNT_ZERO;
    end
    else
    begin
      if (accept_wr && hit(i_avs_address, `TMR_OFF_CMP0))
      begin
        if (i_avs_byteenable[0])
          compare_buffer[7:0] <= i_avs_writedata[7:0];
        if (i_avs_byteenable[1])
          compare_buffer[15:8] <= i_avs_writedata[15:8];
        if (!run.double_buffer_enable && i_avs_byteenable[0])
          compare_zero[7:0] <= i_avs_writedata[7:0];
        if (!run.double_buffer_enable && i_avs_byteenable[1])
          compare_zero[15:8] <= i_avs_writedata[15:8];
      end
      else if (run.double_buffer_enable && match_one)
        compare_zero <= compare_buffer;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      compare_one <= `TMR_CNT_ZERO;
    else if (accept_wr && hit(i_avs_address, `TMR_OFF_CMP1))
    begin
      if (i_avs_byteenable[0])
        compare_one[7:0] <= i_avs_writedata[7:0];
      if (i_avs_byteenable[1])
        compare_one[15:8] <= i_avs_writedata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      clk_pin_sync <= '0;
      cap_pin_sync <= '0;
    end
    else
    begin
      clk_pin_sync <= {clk_pin_sync[1:0], i_ext_clock_input};
      cap_pin_sync <= {cap_pin_sync[1:0], i_capture_input};
    end
  end

  assign clk_rise = clk_pin_sync[1] & ~clk_pin_sync[2];
  assign cap_rise = cap_pin_sync[1] & ~cap_pin_sync[2];
  assign cap_fall = ~cap_pin_sync[1] & cap_pin_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Clock gear, divide by four and prescaler

  assign hold      = i_idle & ~run.idle_run_enable;
  assign gear_tick = ((gear_cnt & gear_mask(mode.clock_gear_select))
                      == gear_mask(mode.clock_gear_select));
  assign phi_t0    = gear_tick && (quarter_cnt == 2'b11);

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      gear_cnt    <= '0;
      quarter_cnt <= '0;
      prescaler   <= '0;
    end
    else if (!run.prescaler_run)
    begin
      gear_cnt    <= '0;
      quarter_cnt <= '0;
      prescaler   <= '0;
    end
    else if (!hold)
    begin
      gear_cnt <= gear_cnt + 4'h1;
      if (gear_tick)
        quarter_cnt <= quarter_cnt + 2'b01;
      if (phi_t0)
        prescaler <= prescaler + 5'h01;
    end
  end

  // Taps every 2, 8 and 32 prescaler clocks
  always_comb
  begin
    unique case (mode.count_clock_select)
      timer_pkg::src_ext : tap_tick = clk_rise;
      timer_pkg::src_t1  : tap_tick = phi_t0 && prescaler[0];
      timer_pkg::src_t4  : tap_tick = phi_t0 && (&prescaler[2:0]);
      timer_pkg::src_t16 : tap_tick = phi_t0 && (&prescaler);
    endcase
  end

  assign count_tick = tap_tick && run.counter_run && run.prescaler_run && !hold;

  ////////////////////////////////////////////////////////////////////////////
  // Up counter, comparators and overflow

  assign clear_hit = mode.match_clear_enable && (up_counter == compare_one);
  assign overflow  = count_tick && !clear_hit && (up_counter == `TMR_CNT_MAX);

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      up_counter <= `TMR_CNT_ZERO;
    else if (!run.counter_run)
      up_counter <= `TMR_CNT_ZERO;
    else if (count_tick && clear_hit)
      up_counter <= `TMR_CNT_ZERO;
    else if (count_tick)
      up_counter <= up_counter + `TMR_CNT_ONE;
  end

  // Match is judged once on the value that a count step produced
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      count_q <= 1'b0;
    else
      count_q <= count_tick;
  end

  assign match_zero = count_q && (up_counter == compare_zero);
  assign match_one  = count_q && (up_counter == compare_one);

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      o_irq <= '0;
    else
    begin
      o_irq.match_zero <= match_zero;
      o_irq.match_one  <= match_one;
      o_irq.overflow   <= overflow;
      o_irq.ext_edge   <= cap_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture control

  // Mode picks both capture events; external interrupt stays on rising edge
  always_comb
  begin
    unique case (mode.capture_mode_select)
      timer_pkg::cap_off      : cap_ev = 2'b00;
      timer_pkg::cap_clk_pin  : cap_ev = {1'b0, clk_rise};
      timer_pkg::cap_trig_pin : cap_ev = {cap_fall, cap_rise};
      timer_pkg::cap_out_flop : cap_ev = {prev_flop_one & ~out_flop[1],
                                          ~prev_flop_one & out_flop[1]};
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      prev_flop_one <= `TMR_FF_RESET;
    else
      prev_flop_one <= out_flop[1];
  end

  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_capture
      always_ff @(posedge i_clk_sys or negedge i_nrst)
      begin
        if (!i_nrst)
          capture[c] <= `TMR_CNT_ZERO;
        else if (cap_ev[c] || (c == 0 && soft_capture))
          capture[c] <= up_counter;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Timer output flops

  assign flop_toggle[0] = (ffcr.zero_on_match_zero && match_zero)
                          || (ffcr.zero_on_match_one && match_one);
  assign flop_toggle[1] = (ffcr.one_on_capture_zero && (cap_ev[0] || soft_capture))
                          || (ffcr.one_on_capture_one && cap_ev[1]);
  assign flop_code[0]   = i_avs_writedata[1:0];
  assign flop_code[1]   = i_avs_writedata[3:2];

  generate
    for (genvar f = 0; f < 2; f++)
    begin : g_flop
      assign flop_wr[f] = accept_wr && hit(i_avs_address, `TMR_OFF_FFCR)
                          && i_avs_byteenable[0];

      always_ff @(posedge i_clk_sys or negedge i_nrst)
      begin
        if (!i_nrst)
          out_flop[f] <= `TMR_FF_RESET;
        else
          out_flop[f] <= flop_next(out_flop[f], flop_wr[f], flop_code[f],
                                   flop_toggle[f]);
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_timer_out_zero <= `TMR_FF_RESET;
      o_timer_out_one  <= `TMR_FF_RESET;
    end
    else
    begin
      o_timer_out_zero <= out_flop[0];
      o_timer_out_one  <= out_flop[1];
    end
  end

endmodule : timer_event_counter

// ### bench/timer_event_counter_sva.sv
// Port checks of the timer channel
`timescale 1ns/1ns
`include "timer_params.svh"
module timer_event_counter_sva (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_nrst,
  input  wire logic [`TMR_ADDR_W-1:0] i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [`TMR_DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  input  wire logic [`TMR_DATA_W-1:0] o_avs_readdata,
  input  wire logic                   o_avs_waitrequest,
  input  wire logic                   i_capture_input,
  input  wire logic                   o_timer_out_zero,
  input  wire logic                   o_timer_out_one,
  input  wire timer_pkg::irq_s        o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic acc_rd;
  logic ff_wr;
  logic [`TMR_ADDR_W-1:0] word;
  assign word   = i_avs_address & 10'h3fc;
  assign acc_rd = i_avs_read && !o_avs_waitrequest;
  assign ff_wr  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                  && word == `TMR_OFF_FFCR;
  ////////////////////////////////////////////////////////////////////////////////
  property p_wait_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wait_cause;
    $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_wait_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered");
  property p_rdata_hold;
    !$stable(o_avs_readdata) |-> $past(i_avs_read);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_cmp_read;
    acc_rd && (word == `TMR_OFF_CMP0 || word == `TMR_OFF_CMP1) |-> o_avs_readdata == '0;
  endproperty
  a_cmp_read: assert property (p_cmp_read) else $error("compare read not zero");
  property p_ext_rise;
    $rose(i_capture_input) |-> ##[2:5] o_irq.ext_edge;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("no edge interrupt");
  property p_ff_set;
    ff_wr && i_avs_writedata[1:0] == 2'b01 |-> ##[2:3] o_timer_out_zero;
  endproperty
  a_ff_set: assert property (p_ff_set) else $error("flop zero not set");
  property p_ff_clear;
    ff_wr && i_avs_writedata[3:2] == 2'b10 |-> ##[2:3] !o_timer_out_one;
  endproperty
  a_ff_clear: assert property (p_ff_clear) else $error("flop one not cleared");
  property p_match_pulse;
    o_irq.match_one |=> !o_irq.match_one;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match irq not a pulse");
  property p_ovf_pulse;
    $rose(o_irq.overflow) |=> $fell(o_irq.overflow);
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow irq not a pulse");
  c_read: cover property (acc_rd);
  c_match: cover property (o_irq.match_one);
  c_ext: cover property (o_irq.ext_edge);
endmodule : timer_event_counter_sva

bind timer_event_counter timer_event_counter_sva u_timer_event_counter_sva (
  .i_clk_sys, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_capture_input,
  .o_timer_out_zero, .o_timer_out_one, .o_irq);

// ### bench/timer_pins_model.sv
// Model of the event clock and capture trigger pins
`timescale 1ns/1ns
module timer_pins_model (
  input  wire logic i_clk_sys,
  output logic      o_ext_clock_input,
  output logic      o_capture_input
);
  initial
  begin
    o_ext_clock_input = 1'b0;
    o_capture_input   = 1'b0;
  end
  // Each level is held long enough for the two-flop synchroniser
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n)
    begin
      @(posedge i_clk_sys) o_ext_clock_input <= 1'b1;
      repeat (hi) @(posedge i_clk_sys);
      o_ext_clock_input <= 1'b0;
      repeat (lo) @(posedge i_clk_sys);
    end
  endtask : pulses
  task automatic trig(input logic lvl);
    @(posedge i_clk_sys) o_capture_input <= lvl;
    repeat (8) @(posedge i_clk_sys);
  endtask : trig
endmodule : timer_pins_model

// ### bench/timer_event_counter_tb.sv
// Self-checking bench of the timer channel
`timescale 1ns/1ns
`include "timer_params.svh"
module timer_event_counter_tb;
  logic                   i_clk_sys;
  logic                   i_nrst;
  logic [`TMR_ADDR_W-1:0] i_avs_address;
  logic                   i_avs_read;
  logic                   i_avs_write;
  logic [`TMR_DATA_W-1:0] i_avs_writedata;
  logic [3:0]             i_avs_byteenable;
  logic [`TMR_DATA_W-1:0] o_avs_readdata;
  logic                   o_avs_waitrequest;
  logic                   i_ext_clock_input;
  logic                   i_capture_input;
  logic                   i_idle;
  logic                   o_timer_out_zero;
  logic                   o_timer_out_one;
  timer_pkg::irq_s        o_irq;
  int                     num_errors;
  int                     compares;
  int                     cycles;
  int                     irq_cnt [4];
  logic [31:0]            lfsr;
  logic [31:0]            rd;

  timer_event_counter u_timer_event_counter (
    .i_clk_sys, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_ext_clock_input,
    .i_capture_input, .i_idle, .o_timer_out_zero, .o_timer_out_one, .o_irq);
  timer_pins_model u_timer_pins_model (
    .i_clk_sys, .o_ext_clock_input(i_ext_clock_input), .o_capture_input(i_capture_input));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // Interrupt pulse counters and run ceiling
  always @(posedge i_clk_sys)
  begin
    cycles <= cycles + 1;
    for (int k = 0; k < 4; k++)
      if (o_irq[k] === 1'b1)
        irq_cnt[k] <= irq_cnt[k] + 1;
    if (cycles == 40000)
    begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_read      <= !w;
    i_avs_write     <= w;
    @(posedge i_clk_sys);
    while (o_avs_waitrequest !== 1'b0)
      @(posedge i_clk_sys);
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_clk_sys);
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk
  task automatic pulses(input int n);
    lfsr = next_rand(lfsr);
    u_timer_pins_model.pulses(n, 1 + lfsr[1:0], 2 + lfsr[3:2]);
    // Let the last count step reach the interrupt and output flops
    repeat (8) @(posedge i_clk_sys);
  endtask : pulses
  task automatic wait_match(output int t);
    int c;
    c = irq_cnt[2];
    while (irq_cnt[2] == c)
      @(posedge i_clk_sys);
    t = cycles;
  endtask : wait_match
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int c;
    int b;
    int t0;
    int t1;
    int g;
    logic [1:0] codes [6];
    logic       exps [6];
    codes = '{2'b01, 2'b00, 2'b00, 2'b10, 2'b00, 2'b11};
    exps = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    {i_nrst, i_avs_read, i_avs_write, i_idle} = 4'h0;
    i_avs_address = '0;
    i_avs_writedata = '0;
    i_avs_byteenable = 4'h3;
    lfsr = 32'h3cf81230;
    {num_errors, compares, cycles} = '0;
    irq_cnt = '{0, 0, 0, 0};
    repeat (16) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    @(posedge i_clk_sys);
    rchk(`TMR_OFF_RUN, `TMR_RUN_RESET);
    rchk(`TMR_OFF_MODE, `TMR_MODE_RESET);
    rchk(`TMR_OFF_CMP0, 32'h0);
    rchk(10'h1fc, 32'h0);
    // Event counting, free run past compare one, idle gating
    wr(`TMR_OFF_CMP1, 32'h3);
    wr(`TMR_OFF_MODE, 32'h020);
    wr(`TMR_OFF_RUN, 32'h05);
    b = irq_cnt[2];
    lfsr = next_rand(lfsr);
    c = 4 + lfsr[3:0];
    pulses(c);
    rchk(`TMR_OFF_COUNT, c);
    check(irq_cnt[2] - b, 1);
    i_idle <= 1'b1;
    pulses(3);
    rchk(`TMR_OFF_COUNT, c);
    wr(`TMR_OFF_RUN, 32'h0d);
    pulses(2);
    c += 2;
    rchk(`TMR_OFF_COUNT, c);
    i_idle <= 1'b0;
    // Software capture
    wr(`TMR_OFF_MODE, 32'h000);
    rchk(`TMR_OFF_CAP0, c);
    pulses(1);
    c++;
    wr(`TMR_OFF_MODE, 32'h020);
    rchk(`TMR_OFF_CAP0, c);
    pulses(1);
    c++;
    wr(`TMR_OFF_MODE, 32'h020);
    rchk(`TMR_OFF_CAP0, c - 1);
    wr(`TMR_OFF_MODE, 32'h000);
    rchk(`TMR_OFF_CAP0, c);
    // Capture modes and the edge interrupt
    wr(`TMR_OFF_MODE, 32'h010);
    b = irq_cnt[0];
    u_timer_pins_model.trig(1'b1);
    rchk(`TMR_OFF_CAP0, c);
    pulses(2);
    c += 2;
    u_timer_pins_model.trig(1'b0);
    rchk(`TMR_OFF_CAP1, c);
    check(irq_cnt[0] - b, 1);
    wr(`TMR_OFF_MODE, 32'h020);
    pulses(1);
    c++;
    wr(`TMR_OFF_MODE, 32'h020);
    u_timer_pins_model.trig(1'b1);
    rchk(`TMR_OFF_CAP0, c - 1);
    check(irq_cnt[0] - b, 2);
    u_timer_pins_model.trig(1'b0);
    wr(`TMR_OFF_MODE, 32'h038);
    wr(`TMR_OFF_FFCR, 32'h07);
    rchk(`TMR_OFF_CAP0, c);
    pulses(2);
    c += 2;
    wr(`TMR_OFF_FFCR, 32'h0b);
    rchk(`TMR_OFF_CAP1, c);
    wr(`TMR_OFF_MODE, 32'h028);
    pulses(1);
    c++;
    rchk(`TMR_OFF_CAP0, c - 1);
    // Flop control codes on both flops
    for (int i = 0; i < 6; i++)
    begin
      wr(`TMR_OFF_FFCR, {28'h0, codes[i], codes[i]});
      @(posedge i_clk_sys);
      check(o_timer_out_zero, exps[i]);
      check(o_timer_out_one, exps[i]);
    end
    // Stop and clear
    wr(`TMR_OFF_RUN, 32'h04);
    rchk(`TMR_OFF_COUNT, 32'h0);
    wr(`TMR_OFF_RUN, 32'h01);
    pulses(2);
    rchk(`TMR_OFF_COUNT, 32'h0);
    // Double buffer, match clear and toggle on match
    wr(`TMR_OFF_MODE, 32'h024);
    wr(`TMR_OFF_CMP1, 32'h5);
    wr(`TMR_OFF_RUN, 32'h05);
    wr(`TMR_OFF_CMP0, 32'h2);
    wr(`TMR_OFF_RUN, 32'h85);
    i_avs_byteenable <= 4'h1;
    wr(`TMR_OFF_CMP0, 32'h4);
    i_avs_byteenable <= 4'h2;
    wr(`TMR_OFF_CMP0, 32'h0);
    i_avs_byteenable <= 4'h3;
    wr(`TMR_OFF_FFCR, 32'h1f);
    b = irq_cnt[1];
    pulses(3);
    check(irq_cnt[1] - b, 1);
    check(o_timer_out_zero, 1'b0);
    pulses(6);
    check(irq_cnt[1] - b, 1);
    pulses(1);
    check(irq_cnt[1] - b, 2);
    check(o_timer_out_zero, 1'b1);
    rchk(`TMR_OFF_COUNT, 32'h4);
    // Prescaler taps at a random gear
    for (int s = 1; s < 4; s++)
    begin
      wr(`TMR_OFF_RUN, 32'h00);
      lfsr = next_rand(lfsr);
      g = lfsr[0];
      wr(`TMR_OFF_MODE, (g << 6) | 32'h024 | s);
      wr(`TMR_OFF_CMP1, 32'h3);
      wr(`TMR_OFF_RUN, 32'h05);
      wait_match(t0);
      wait_match(t1);
      check(t1 - t0, 32 * (4 ** (s - 1)) * (1 << g));
    end
    tally_and_finish();
  end
endmodule : timer_event_counter_tb
